// *** hdl/rcpt_timer.sv ***
// Reload/capture PWM timer: 8-bit up-counter behind a 7-bit prescaler.
// Assumes registers reached over a one-cycle strobe port and an asynchronous input pin.
//
// Added by the designer: the plain strobed port.
`timescale 1ns/10ps
`include "rcpt_defines.svh"

module rcpt_timer (
   // Clock and reset
   input  wire logic                clk_i,
   input  wire logic                rstn_i,
   // Register port
   input  wire rcpt_pkg::rcpt_bus_req_t bus_i,
   output logic [7:0]               rdata_o,
   // Pins
   input  wire logic                timer_input_pin_i,
   output logic                     pwm_output_pin_o,
   // Interrupt requests: edge, match, wrap
   output logic [2:0]               irq_o
);
   import rcpt_pkg::*;

   rcpt_state_t s_r;
   rcpt_state_t s_nxt;

   // Tap of the 7-bit prescaler: ratio 2^code, code 0 passes every source tick
   function automatic logic presc_tap(input logic [6:0] p, input logic [2:0] code);
      logic [6:0] mask;
      mask = 7'h7f >> (3'd7 - code);
      presc_tap = ((p & mask) == mask);
   endfunction

   function automatic logic addr_hit(input rcpt_bus_req_t b, input logic [7:0] a);
      addr_hit = (b.addr == a);
   endfunction

   logic       wr_mode;
   logic       wr_flags;
   logic       src_tick;
   logic       cnt_tick;
   logic       pin_edge;
   logic       cnt_en;
   logic       loading;
   logic [7:0] load_val;
   logic [7:0] cnt_inc;
   rcpt_mode_t mode;
   rcpt_src_t  src;

   always_comb begin
      s_nxt    = s_r;
      mode     = rcpt_mode_t'(s_r.mode_ctl[1:0]);
      src      = rcpt_src_t'(s_r.clk_sel[1:0]);
      cnt_en   = s_r.mode_ctl[`RCPT_BIT_COUNT_ENABLE];
      wr_mode  = bus_i.wr && addr_hit(bus_i, `RCPT_ADDR_MODE_CONTROL);
      wr_flags = bus_i.wr && addr_hit(bus_i, `RCPT_ADDR_FLAG_STATUS);
      loading  = 1'b0;
      load_val = s_r.reload_cap;

      // Synchroniser: only the second stage is looked at
      s_nxt.pin_sync = {s_r.pin_sync[0], timer_input_pin_i};
      s_nxt.pin_prev = s_r.pin_sync[1];
      pin_edge = s_r.clk_sel[`RCPT_BIT_EDGE_ON] &&
                 (s_r.clk_sel[`RCPT_BIT_EDGE_POL] ?
                  (s_r.pin_prev && !s_r.pin_sync[1]) :
                  (!s_r.pin_prev && s_r.pin_sync[1]));

      // Divide-by-3 runs free; source mux
      if (s_r.div3 == `RCPT_DIV3_LAST) begin
         s_nxt.div3 = 2'h0;
      end else begin
         s_nxt.div3 = s_r.div3 + 2'h1;
      end
      case (src)
         RCPT_SRC_INT:  src_tick = 1'b1;
         RCPT_SRC_DIV3: src_tick = (s_r.div3 == `RCPT_DIV3_LAST);
         RCPT_SRC_PIN:  src_tick = !s_r.pin_prev && s_r.pin_sync[1];
         default:       src_tick = 1'b0;
      endcase
      // In pin-clock mode the edge also clocks, as the rising sample above
      cnt_tick = cnt_en && src_tick && presc_tap(s_r.presc, s_r.clk_sel[7:5]);

      cnt_inc = s_r.count + 8'h01;
      if (cnt_en && src_tick) begin
         s_nxt.presc = s_r.presc + 7'h01;
      end
      if (cnt_tick) begin
         s_nxt.count = cnt_inc;
         if (s_r.count == `RCPT_COUNT_WRAP) begin
            s_nxt.flags[`RCPT_BIT_WRAP_FLAG] = 1'b1;
            s_nxt.pwm_level = 1'b1;
            if (mode == RCPT_MODE_RELOAD) begin
               loading = 1'b1;
            end
         end
      end
      // Match checked on the value the counter holds
      if (s_r.count == s_r.compare && cnt_en) begin
         s_nxt.flags[`RCPT_BIT_MATCH_FLAG] = 1'b1;
         s_nxt.pwm_level = 1'b0;
      end

      // Input edge events
      if (pin_edge) begin
         s_nxt.flags[`RCPT_BIT_EDGE_FLAG] = 1'b1;
         case (mode)
            RCPT_MODE_CAPTURE: begin
               s_nxt.reload_cap = s_r.count;
            end
            RCPT_MODE_CAP_RST: begin
               s_nxt.reload_cap = s_r.count;
               loading  = 1'b1;
               load_val = `RCPT_ZERO8;
            end
            RCPT_MODE_EXT_LD: begin
               loading = 1'b1;
            end
            default: begin
            end
         endcase
      end

      // Register writes
      if (bus_i.wr) begin
         case (bus_i.addr)
            `RCPT_ADDR_MODE_CONTROL: begin
               s_nxt.mode_ctl = {1'b0, bus_i.wdata[6:0]};
            end
            `RCPT_ADDR_CLOCK_SELECT:   s_nxt.clk_sel    = bus_i.wdata;
            `RCPT_ADDR_RELOAD_CAPTURE: s_nxt.reload_cap = bus_i.wdata;
            `RCPT_ADDR_COMPARE:        s_nxt.compare    = bus_i.wdata;
            default: begin
            end
         endcase
      end
      if (wr_mode && bus_i.wdata[`RCPT_BIT_LOAD_STROBE]) begin
         loading  = 1'b1;
         load_val = s_r.reload_cap;
      end
      if (bus_i.wr && addr_hit(bus_i, `RCPT_ADDR_ON_THE_FLY)) begin
         loading  = 1'b1;
         load_val = bus_i.wdata;
      end
      // Written zeros clear; a flag newly set this cycle wins over the clear
      if (wr_flags) begin
         s_nxt.flags = s_nxt.flags & (bus_i.wdata[2:0] | (s_nxt.flags & ~s_r.flags));
      end
      if (loading) begin
         s_nxt.count = load_val;
         s_nxt.presc = 7'h00;
      end

      // Outputs registered; requests held until flag or its enable cleared
      s_nxt.pwm_pin = s_nxt.pwm_level && s_nxt.mode_ctl[`RCPT_BIT_PWM_DRIVE];
      s_nxt.irq = s_nxt.flags & s_nxt.mode_ctl[4:2];

      s_nxt.rdata = 8'h00;
      if (bus_i.rd) begin
         case (bus_i.addr)
            `RCPT_ADDR_MODE_CONTROL:   s_nxt.rdata = {1'b0, s_r.mode_ctl[6:0]};
            `RCPT_ADDR_FLAG_STATUS:    s_nxt.rdata = {5'h00, s_r.flags};
            `RCPT_ADDR_CLOCK_SELECT:   s_nxt.rdata = s_r.clk_sel;
            `RCPT_ADDR_RELOAD_CAPTURE: s_nxt.rdata = s_r.reload_cap;
            `RCPT_ADDR_COMPARE:        s_nxt.rdata = s_r.compare;
            `RCPT_ADDR_ON_THE_FLY:     s_nxt.rdata = s_r.count;
            `RCPT_ADDR_PRESCALER:      s_nxt.rdata = {1'b0, s_r.presc};
            default:                   s_nxt.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r          <= '0;
         s_r.mode_ctl <= `RCPT_MODE_CONTROL_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign rdata_o          = s_r.rdata;
   assign pwm_output_pin_o = s_r.pwm_pin;
   assign irq_o            = s_r.irq;
endmodule

// *** hdl/rcpt_defines.svh ***
// Register offsets, field positions and reset values of the reload/capture PWM timer.
// Assumes a byte-wide register port with 8-bit addresses.
`ifndef RCPT_DEFINES_SVH
`define RCPT_DEFINES_SVH
`define RCPT_ADDR_CLOCK_SELECT   8'hd7
`define RCPT_ADDR_MODE_CONTROL   8'hd5
`define RCPT_ADDR_FLAG_STATUS    8'hd6
`define RCPT_ADDR_RELOAD_CAPTURE 8'hd9
`define RCPT_ADDR_COMPARE        8'hda
`define RCPT_ADDR_ON_THE_FLY     8'hdb
`define RCPT_ADDR_PRESCALER      8'hd8
`define RCPT_MODE_CONTROL_RESET  8'h00
`define RCPT_BIT_LOAD_STROBE     7
`define RCPT_BIT_COUNT_ENABLE    6
`define RCPT_BIT_PWM_DRIVE       5
`define RCPT_BIT_EDGE_IE         4
`define RCPT_BIT_MATCH_IE        3
`define RCPT_BIT_WRAP_IE         2
`define RCPT_BIT_EDGE_FLAG       2
`define RCPT_BIT_MATCH_FLAG      1
`define RCPT_BIT_WRAP_FLAG       0
`define RCPT_BIT_EDGE_ON         2
`define RCPT_BIT_EDGE_POL        3
`define RCPT_DIV3_LAST           2'h2
`define RCPT_COUNT_WRAP          8'hff
`define RCPT_ZERO8               8'h00
`endif

// *** hdl/rcpt_pkg.sv ***
// Types shared by the reload/capture PWM timer.
// Assumes rcpt_defines.svh for numeric constants.
package rcpt_pkg;
   typedef enum logic [1:0] {
      RCPT_MODE_RELOAD  = 2'b00,
      RCPT_MODE_CAPTURE = 2'b01,
      RCPT_MODE_CAP_RST = 2'b10,
      RCPT_MODE_EXT_LD  = 2'b11
   } rcpt_mode_t;

   typedef enum logic [1:0] {
      RCPT_SRC_INT  = 2'b00,
      RCPT_SRC_DIV3 = 2'b01,
      RCPT_SRC_PIN  = 2'b10,
      RCPT_SRC_RSVD = 2'b11
   } rcpt_src_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } rcpt_bus_req_t;

   typedef struct packed {
      logic [7:0] mode_ctl;
      logic [2:0] flags;
      logic [7:0] clk_sel;
      logic [7:0] reload_cap;
      logic [7:0] compare;
      logic [7:0] count;
      logic [6:0] presc;
      logic [1:0] div3;
      logic [1:0] pin_sync;
      logic       pin_prev;
      logic       pwm_level;
      logic       pwm_pin;
      logic [2:0] irq;
      logic [7:0] rdata;
   } rcpt_state_t;
endpackage

// *** tb/rcpt_timer_chk.sv ***
// Port-level assertions for rcpt_timer.
// Assumes mode control changes only through bus writes.
`timescale 1ns/10ps
module rcpt_timer_chk (
   // Clock and reset
   input wire logic                     clk_i,
   input wire logic                     rstn_i,
   // Register port
   input wire rcpt_pkg::rcpt_bus_req_t  bus_i,
   input wire logic [7:0]               rdata_o,
   // Pins and requests
   input wire logic                     timer_input_pin_i,
   input wire logic                     pwm_output_pin_o,
   input wire logic [2:0]               irq_o
);
   import rcpt_pkg::*;
   // Shadow of mode control, so enables can be judged from outside
   logic [7:0] sh_r;
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) sh_r <= 8'h00;
      else if (bus_i.wr && bus_i.addr == 8'hd5) sh_r <= bus_i.wdata;
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   sequence s_rd(a); bus_i.rd && bus_i.addr == a; endsequence
   sequence s_off(b); bus_i.wr && bus_i.addr == 8'hd5 && !bus_i.wdata[b]; endsequence
   AST_CTL_READ:
   assert property (s_rd(8'hd5) |=> rdata_o == {1'b0, $past(sh_r[6:0])}) else $error("ctl read");
   AST_FLAG_TOP:
   assert property (s_rd(8'hd6) |=> rdata_o[7:3] == 5'h00) else $error("flag top bits");
   AST_UNMAPPED:
   assert property (s_rd(8'he0) |=> rdata_o == 8'h00) else $error("unmapped read");
   AST_RD_IDLE:
   assert property (!$past(bus_i.rd) |-> rdata_o == 8'h00) else $error("rdata without read");
   AST_IRQ_MASK:
   assert property ((irq_o & ~(sh_r[4:2] | $past(sh_r[4:2]))) == 3'h0) else $error("irq masked");
   AST_PWM_GATE:
   assert property (pwm_output_pin_o |-> sh_r[5] || $past(sh_r[5])) else $error("pwm gate");
   AST_PWM_OFF:
   assert property (s_off(5) |=> !pwm_output_pin_o) else $error("pwm not off");
   AST_IRQ_OFF:
   assert property (s_off(2) |=> !irq_o[0]) else $error("wrap irq not off");
endmodule
bind rcpt_timer rcpt_timer_chk chk_u (.clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus_i),
   .rdata_o(rdata_o), .timer_input_pin_i(timer_input_pin_i),
   .pwm_output_pin_o(pwm_output_pin_o), .irq_o(irq_o));

// *** tb/rcpt_pin_model.sv ***
// Event source on the timer input pin and load on the PWM pin.
// Assumes fire_i is a one-cycle request from the bench.
`timescale 1ns/10ps
module rcpt_pin_model (
   // Clock and control
   input wire logic   clk_i,
   input wire logic   fire_i,
   // Pins
   input wire logic   pwm_i,
   output logic       pin_o,
   output logic [7:0] hi_o
);
   logic [2:0] w_r;
   initial begin
      pin_o = 1'b0;
      w_r = 3'h0;
      hi_o = 8'h00;
   end
   // Driven low between pulses; never used as a count clock
   always @(posedge clk_i) begin
      hi_o <= hi_o + {7'h0, pwm_i};
      w_r <= fire_i ? 3'h7 : (w_r != 3'h0 ? w_r - 3'h1 : 3'h0);
      pin_o <= fire_i || w_r > 3'h4;
   end
endmodule

// *** tb/testbench.sv ***
// Self-checking bench for rcpt_timer.
// Assumes the pin model and the bound checker are compiled alongside.
`timescale 1ns/10ps
module testbench;
   import rcpt_pkg::*;
   logic          clk_i = 1'b0;
   logic          rstn_i = 1'b0;
   rcpt_bus_req_t bus_i = '0;
   logic [7:0]    rdata_o, hi, h0, e9, eb;
   logic          pin, pwm, fire = 1'b0, rd_d = 1'b0;
   logic [2:0]    irq_o;
   logic [15:0]   q[$], me;
   logic [31:0]   rng = 32'd6;
   int            failures = 0, compares = 0, cyc = 0;
   always #12.5 clk_i = ~clk_i;
   rcpt_timer dut_u (.clk_i(clk_i), .rstn_i(rstn_i), .bus_i(bus_i), .rdata_o(rdata_o),
      .timer_input_pin_i(pin), .pwm_output_pin_o(pwm), .irq_o(irq_o));
   rcpt_pin_model pin_u (.clk_i(clk_i), .fire_i(fire), .pwm_i(pwm), .pin_o(pin), .hi_o(hi));
   function automatic logic [31:0] xs(logic [31:0] x);
      x ^= x << 13;
      x ^= x >> 17;
      x ^= x << 5;
      return x;
   endfunction
   task automatic chk(string n, logic [7:0] got, logic [7:0] e);
      compares++;
      if (got !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, got);
      end
   endtask
   task finish_test;
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // Idle cycle after each access keeps strobes single and unambiguous
   task automatic op(logic w, logic [7:0] a, logic [7:0] d);
      bus_i <= '{a, d, w, !w};
      @(posedge clk_i);
      bus_i <= '0;
      @(posedge clk_i);
   endtask
   task automatic wr(logic [7:0] a, logic [7:0] d); op(1'b1, a, d); endtask
   task automatic rd(logic [7:0] a, logic [7:0] e); q.push_back({a, e}); op(1'b0, a, 8'h00); endtask
   always @(posedge clk_i) begin
      rd_d <= bus_i.rd;
      if (rd_d) begin
         me = q.pop_front();
         chk("rdata", rdata_o, me[7:0]);
      end
      cyc++;
      if (cyc == 20000) begin
         failures++;
         finish_test();
      end
   end
   initial begin
      repeat (16) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      rd(8'hd5, 8'h00);
      rd(8'hd6, 8'h00);
      rd(8'he0, 8'h00);
      for (int i = 0; i < 4; i++) begin
         rng = xs(rng);
         wr(8'hd5, rng[7:0]);
         rd(8'hd5, {1'b0, rng[6:0]});
      end
      $display("test registers done");
      wr(8'hd5, 8'h00);
      wr(8'hd6, 8'h00);
      wr(8'hd7, 8'h00);
      wr(8'hd9, 8'hfc);
      wr(8'hda, 8'hfe);
      rd(8'hda, 8'hfe);
      wr(8'hd5, 8'he4);
      h0 = hi;
      repeat (40) @(posedge clk_i);
      @(negedge clk_i);
      chk("irq", {5'h0, irq_o}, 8'h01);
      chk("pwm_active", {7'h0, hi != h0 && hi - h0 < 8'd40}, 8'h01);
      @(posedge clk_i);
      wr(8'hd5, 8'h00);
      h0 = hi;
      repeat (20) @(posedge clk_i);
      chk("pwm_off", hi, h0);
      rd(8'hd6, 8'h03);
      wr(8'hd6, 8'h06);
      rd(8'hd6, 8'h02);
      wr(8'hd6, 8'hff);
      rd(8'hd6, 8'h02);
      wr(8'hd6, 8'h00);
      rd(8'hd6, 8'h00);
      $display("test auto_reload done");
      wr(8'hd7, 8'h04);
      rd(8'hd7, 8'h04);
      for (int m = 0; m < 4; m++) begin
         wr(8'hd5, 8'h10 | m[7:0]);
         wr(8'hd9, 8'h77);
         wr(8'hdb, 8'h55);
         wr(8'hd6, 8'h00);
         rd(8'hdb, 8'h55);
         fire <= 1'b1;
         @(posedge clk_i);
         fire <= 1'b0;
         repeat (8) @(posedge clk_i);
         e9 = (m == 1 || m == 2) ? 8'h55 : 8'h77;
         eb = (m == 2) ? 8'h00 : e9;
         rd(8'hd9, e9);
         rd(8'hdb, (m == 0) ? 8'h55 : eb);
         rd(8'hd6, 8'h04);
         @(negedge clk_i);
         chk("irq", {5'h0, irq_o}, 8'h04);
         @(posedge clk_i);
      end
      $display("test edge_modes done");
      finish_test();
   end
endmodule
